// ---- include/adc_seq_defs.vh ----
// Constants for the converter input-configuration and channel-sequencer block
`ifndef ADC_SEQ_DEFS_VH
`define ADC_SEQ_DEFS_VH

// Configuration word layout
`define CFG_WIDTH        14
`define CFG_RESET        14'h0000
`define CFG_UPDATE_BIT   13
`define CFG_INPUT_CONFIGURATION_FIELD_HI      12
`define CFG_INPUT_CONFIGURATION_FIELD_LO      10
`define CFG_SINGLE_BIT   11
`define CFG_BIPOLAR_BIT  12
`define CFG_CH_HI        9
`define CFG_CH_LO        7
`define CFG_BW_BIT       6
`define CFG_REF_HI       5
`define CFG_REF_LO       3
`define CFG_SEQ_HI       2
`define CFG_SEQ_LO       1
`define CFG_RB_BIT       0

// Input-configuration codes
`define INPUT_CONFIGURATION_FIELD_SINGLE_GND  3'h7
`define INPUT_CONFIGURATION_FIELD_COM_BIPOLAR 3'h2
`define INPUT_CONFIGURATION_FIELD_COM_UNIPOL  3'h6
`define PAIR_BIPOLAR     2'h0
`define PAIR_UNIPOLAR    2'h2

// Sequencer-mode codes
`define SEQ_OFF          2'h0
`define SEQ_UPDATE       2'h1
`define SEQ_SCAN_TEMP    2'h2
`define SEQ_SCAN         2'h3

// Filter bandwidth bit value for full bandwidth
`define BW_FULL          1'h1

// Negative input selection codes
`define NEG_GND          2'h0
`define NEG_COM          2'h1
`define NEG_PAIR         2'h2

// Synchroniser depth for pin inputs
`define SYNC_STAGES      2

// Serial edge counts of one configuration word, sized for the bit counter
`define CFG_COUNT        4'hE
`define CFG_LAST_COUNT   4'hD

`endif

// ---- logic/pin_sync.v ----
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ns
`include "adc_seq_defs.vh"

module pin_sync
#(
  parameter WIDTH = 3
)
(
  input  wire             clk_i,
  input  wire             sys_rst_i,
  input  wire [WIDTH-1:0] pin_i,
  output wire [WIDTH-1:0] sync_o
);

  genvar g;

  ////////////////////////////////////////////////////////////////////////////
  // One chain per bit; the first stage feeds only the second
  generate
    for (g = 0; g < WIDTH; g = g + 1)
    begin : g_bit
      reg [`SYNC_STAGES-1:0] chain;
      always @(posedge clk_i or posedge sys_rst_i)
      begin
        if (sys_rst_i)
          chain <= {`SYNC_STAGES{1'b0}};
        else
          chain <= {chain[`SYNC_STAGES-2:0], pin_i[g]};
      end
      assign sync_o[g] = chain[`SYNC_STAGES-1];
    end
  endgenerate

endmodule // pin_sync

// ---- logic/cfg_shifter.v ----
// Serial shifter that captures the configuration word from the host port
`timescale 1ns/1ns
`include "adc_seq_defs.vh"

module cfg_shifter
(
  input  wire                  clk_i,
  input  wire                  sys_rst_i,
  input  wire                  sck_s_i,
  input  wire                  cnv_s_i,
  input  wire                  din_s_i,
  output reg  [`CFG_WIDTH-1:0] word_o,
  output reg                   done_o
);

  reg       sck_d;
  reg [3:0] bit_cnt;

  wire sck_rise = sck_s_i & ~sck_d;

  ////////////////////////////////////////////////////////////////////////////
  // Shift on the first CFG_WIDTH rising serial edges while convert is low
  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      sck_d   <= 1'b0;
      bit_cnt <= 4'h0;
      word_o  <= `CFG_RESET;
      done_o  <= 1'b0;
    end
    else
    begin
      sck_d  <= sck_s_i;
      done_o <= 1'b0;
      // Convert high ends the transfer; a partial word is simply dropped
      if (cnv_s_i)
        bit_cnt <= 4'h0;
      else if (sck_rise && (bit_cnt < `CFG_COUNT))
      begin
        word_o  <= {word_o[`CFG_WIDTH-2:0], din_s_i};
        bit_cnt <= bit_cnt + 4'h1;
        if (bit_cnt == `CFG_LAST_COUNT)
          done_o <= 1'b1;
      end
    end
  end

endmodule // cfg_shifter

// ---- logic/adc_input_config_sequencer.v ----
// Input configuration decode and channel sequencer of an 8-channel converter
`timescale 1ns/1ns
`include "adc_seq_defs.vh"

module adc_input_config_sequencer
#(
  parameter CH_BITS = 3
)
(
  input  wire                  clk_i,
  input  wire                  sys_rst_i,
  input  wire                  convert_start_pin_i,
  input  wire                  sck_i,
  input  wire                  din_i,
  output reg  [`CFG_WIDTH-1:0] config_word_o,
  output reg                   conv_select_o,
  output reg  [CH_BITS-1:0]    positive_input_o,
  output reg  [CH_BITS-1:0]    negative_input_o,
  output reg  [1:0]            negative_select_o,
  output reg                   negative_half_ref_o,
  output reg                   temp_select_o,
  output reg                   twos_complement_o,
  output reg                   bw_quarter_o,
  output reg  [2:0]            ref_select_o,
  output reg                   config_readback_o,
  output reg                   seq_active_o
);

  // Sequencer states
  localparam ST_IDLE = 2'h0;
  localparam ST_SCAN = 2'h1;
  localparam ST_TEMP = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation

  wire [2:0] pins_s;
  wire       cnv_s = pins_s[0];
  wire       sck_s = pins_s[1];
  wire       din_s = pins_s[2];

  // All three pins come from the host's clock domain
  pin_sync #(
    .WIDTH (3)
  ) u_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .pin_i     ({din_i, sck_i, convert_start_pin_i}),
    .sync_o    (pins_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Configuration word capture

  wire [`CFG_WIDTH-1:0] shift_word;
  wire                  shift_done;

  cfg_shifter u_shift (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .sck_s_i   (sck_s),
    .cnv_s_i   (cnv_s),
    .din_s_i   (din_s),
    .word_o    (shift_word),
    .done_o    (shift_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State

  reg [`CFG_WIDTH-1:0] cfg;         // Active configuration word
  reg [1:0]            state;
  reg [CH_BITS-1:0]    idx;         // Next input to convert in a scan
  reg                  with_temp;   // Scan ends with the temperature sensor
  reg                  cnv_d;

  reg [1:0]            next_state;
  reg [CH_BITS-1:0]    next_idx;
  reg                  next_with_temp;
  reg [CH_BITS-1:0]    next_pos;
  reg [CH_BITS-1:0]    next_neg;
  reg [1:0]            next_neg_sel;
  reg                  next_temp;

  // A word is applied only when its update bit is set; a host that keeps
  // the data line low while reading leaves the active word untouched
  wire word_apply = shift_done & shift_word[`CFG_UPDATE_BIT];

  // Conversion start is the rising edge of the synchronised convert pin
  wire conv_start = cnv_s & ~cnv_d;

  ////////////////////////////////////////////////////////////////////////////
  // Field decode of the active word

  wire [2:0]         input_configuration_field     = cfg[`CFG_INPUT_CONFIGURATION_FIELD_HI:`CFG_INPUT_CONFIGURATION_FIELD_LO];
  wire [CH_BITS-1:0] ch_field = cfg[`CFG_CH_HI:`CFG_CH_LO];

  // Pairs when the single-or-paired bit is clear: codes 00X and 10X
  wire paired = ~cfg[`CFG_SINGLE_BIT];
  // Bipolar when the top input bit is clear: codes 00X, 010 and 011
  wire bipolar = ~cfg[`CFG_BIPOLAR_BIT];

  // Last input of a scan; for pairs the last channel names its pair
  wire [CH_BITS-1:0] last_idx = paired ? {ch_field[CH_BITS-1:1], 1'b0} : ch_field;

  // Step of one input for singles, two for pairs
  wire [CH_BITS-1:0] step = paired ? 3'h2 : 3'h1;

  // Fields that force a restart when they change under an update write
  wire restart_change = (shift_word[`CFG_SINGLE_BIT] != cfg[`CFG_SINGLE_BIT]) ||
                        (shift_word[`CFG_CH_HI:`CFG_CH_LO] != ch_field);

  ////////////////////////////////////////////////////////////////////////////
  // Negative side of the multiplexer for the single and common modes

  reg [1:0] common_neg_sel;

  always @*
  begin
    if (input_configuration_field == `INPUT_CONFIGURATION_FIELD_SINGLE_GND)
      common_neg_sel = `NEG_GND;
    else if ((input_configuration_field == `INPUT_CONFIGURATION_FIELD_COM_BIPOLAR) || (input_configuration_field == `INPUT_CONFIGURATION_FIELD_COM_UNIPOL))
      common_neg_sel = `NEG_COM;
    else
      common_neg_sel = `NEG_COM;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel selection for the conversion that is starting

  always @*
  begin
    next_temp    = 1'b0;
    next_pos     = ch_field;
    next_neg     = ch_field;
    next_neg_sel = common_neg_sel;
    case (state)
      ST_TEMP:
      begin
        // Temperature sensor is read against ground
        next_temp    = 1'b1;
        next_pos     = {CH_BITS{1'b0}};
        next_neg     = {CH_BITS{1'b0}};
        next_neg_sel = `NEG_GND;
      end
      ST_SCAN:
      begin
        if (paired)
        begin
          // Scanned pairs ignore the low channel bit entirely
          next_pos     = {idx[CH_BITS-1:1], 1'b0};
          next_neg     = {idx[CH_BITS-1:1], 1'b1};
          next_neg_sel = `NEG_PAIR;
        end
        else
        begin
          next_pos = idx;
          next_neg = idx;
        end
      end
      ST_IDLE:
      begin
        if (paired)
        begin
          // Channel field is the positive input, its partner the negative
          next_pos     = ch_field;
          next_neg     = ch_field ^ 3'h1;
          next_neg_sel = `NEG_PAIR;
        end
      end
      default:
      begin
        next_temp    = 1'b0;
        next_pos     = ch_field;
        next_neg     = ch_field;
        next_neg_sel = common_neg_sel;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer next state; a word write takes priority over a conversion

  always @*
  begin
    next_state     = state;
    next_idx       = idx;
    next_with_temp = with_temp;
    if (word_apply)
    begin
      case (shift_word[`CFG_SEQ_HI:`CFG_SEQ_LO])
        `SEQ_OFF:
        begin
          next_state = ST_IDLE;
          next_idx   = {CH_BITS{1'b0}};
        end
        `SEQ_UPDATE:
        begin
          // Keep scanning; restart from input 0 only on a layout change
          if ((state != ST_IDLE) && restart_change)
          begin
            next_state = ST_SCAN;
            next_idx   = {CH_BITS{1'b0}};
          end
        end
        `SEQ_SCAN_TEMP:
        begin
          next_state     = ST_SCAN;
          next_idx       = {CH_BITS{1'b0}};
          next_with_temp = 1'b1;
        end
        `SEQ_SCAN:
        begin
          next_state     = ST_SCAN;
          next_idx       = {CH_BITS{1'b0}};
          next_with_temp = 1'b0;
        end
        default:
        begin
          next_state = state;
        end
      endcase
    end
    else if (conv_start)
    begin
      case (state)
        ST_SCAN:
        begin
          if (idx == last_idx)
          begin
            // End of the channel list: temperature or wrap
            next_idx   = {CH_BITS{1'b0}};
            next_state = with_temp ? ST_TEMP : ST_SCAN;
          end
          else
            next_idx = idx + step;
        end
        ST_TEMP:
        begin
          next_state = ST_SCAN;
          next_idx   = {CH_BITS{1'b0}};
        end
        ST_IDLE:
        begin
          next_state = ST_IDLE;
        end
        default:
        begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Active word and sequencer registers

  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      cfg       <= `CFG_RESET;
      state     <= ST_IDLE;
      idx       <= {CH_BITS{1'b0}};
      with_temp <= 1'b0;
      cnv_d     <= 1'b0;
    end
    else
    begin
      cnv_d     <= cnv_s;
      state     <= next_state;
      idx       <= next_idx;
      with_temp <= next_with_temp;
      // The whole word changes at once, never bit by bit
      if (word_apply)
        cfg <= shift_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs; the selection is held for the whole conversion

  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      config_word_o       <= `CFG_RESET;
      conv_select_o       <= 1'b0;
      positive_input_o    <= {CH_BITS{1'b0}};
      negative_input_o    <= {CH_BITS{1'b0}};
      negative_select_o   <= `NEG_GND;
      negative_half_ref_o <= 1'b0;
      temp_select_o       <= 1'b0;
      twos_complement_o   <= 1'b0;
      bw_quarter_o        <= 1'b0;
      ref_select_o        <= 3'h0;
      config_readback_o   <= 1'b0;
      seq_active_o        <= 1'b0;
    end
    else
    begin
      config_word_o     <= cfg;
      seq_active_o      <= (state != ST_IDLE);
      // Filter and reference settings follow the active word directly
      bw_quarter_o      <= (cfg[`CFG_BW_BIT] != `BW_FULL);
      ref_select_o      <= cfg[`CFG_REF_HI:`CFG_REF_LO];
      config_readback_o <= cfg[`CFG_RB_BIT];
      conv_select_o     <= conv_start;
      if (conv_start)
      begin
        positive_input_o    <= next_pos;
        negative_input_o    <= next_neg;
        negative_select_o   <= next_neg_sel;
        temp_select_o       <= next_temp;
        // Half-reference negative side only for bipolar inputs
        negative_half_ref_o <= bipolar & ~next_temp;
        // Sensor results are straight binary whatever the input mode
        twos_complement_o   <= bipolar & ~next_temp;
      end
    end
  end

endmodule // adc_input_config_sequencer

// ---- tb/adc_seq_chk.sv ----
// Port-level checks of the input decoder and sequencer
`timescale 1ns/1ns
`include "adc_seq_defs.vh"
module adc_seq_chk
#(
  parameter CH_BITS = 3
)
(
  input wire                  clk_i,
  input wire                  sys_rst_i,
  input wire [`CFG_WIDTH-1:0] config_word_o,
  input wire                  conv_select_o,
  input wire [CH_BITS-1:0]    positive_input_o,
  input wire [CH_BITS-1:0]    negative_input_o,
  input wire [1:0]            negative_select_o,
  input wire                  negative_half_ref_o,
  input wire                  temp_select_o,
  input wire                  twos_complement_o,
  input wire                  bw_quarter_o,
  input wire                  seq_active_o
);
  reg  [`CFG_WIDTH-1:0] word_d1;
  reg  [`CFG_WIDTH-1:0] word_d2;
  wire [2:0]            in_code = config_word_o[12:10];
  wire                  settled = (word_d1 == config_word_o) && (word_d2 == config_word_o);
  //////////////////////////////////////////////////////////////////////////////
  // Old copies of the word; a conversion just after an update may use either
  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      word_d1 <= `CFG_RESET;
      word_d2 <= `CFG_RESET;
    end
    else
    begin
      word_d1 <= config_word_o;
      word_d2 <= word_d1;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // A channel conversion with a settled word
  sequence s_sel;
    conv_select_o && settled && !temp_select_o;
  endsequence
  AST_BW: assert property (conv_select_o && settled |-> bw_quarter_o == !config_word_o[6])
    else $error("filter setting does not follow the word");
  AST_SGL_GND: assert property (s_sel ##0 (in_code == `INPUT_CONFIGURATION_FIELD_SINGLE_GND)
    |-> negative_select_o == `NEG_GND && !twos_complement_o) else $error("ground mode wrong");
  AST_COM_BIP: assert property (s_sel ##0 (in_code == `INPUT_CONFIGURATION_FIELD_COM_BIPOLAR)
    |-> negative_select_o == `NEG_COM && negative_half_ref_o && twos_complement_o)
    else $error("bipolar common mode wrong");
  AST_COM_UNI: assert property (s_sel ##0 (in_code == `INPUT_CONFIGURATION_FIELD_COM_UNIPOL)
    |-> negative_select_o == `NEG_COM && !negative_half_ref_o && !twos_complement_o)
    else $error("unipolar common mode wrong");
  AST_PAIR_BIP: assert property (s_sel ##0 (in_code[2:1] == `PAIR_BIPOLAR)
    |-> negative_select_o == `NEG_PAIR && negative_half_ref_o && twos_complement_o)
    else $error("bipolar pair mode wrong");
  AST_PAIR_UNI: assert property (s_sel ##0 (in_code[2:1] == `PAIR_UNIPOLAR)
    |-> negative_select_o == `NEG_PAIR && !negative_half_ref_o && !twos_complement_o)
    else $error("unipolar pair mode wrong");
  AST_IDLE_PAIR: assert property (s_sel ##0 (!seq_active_o && !config_word_o[11])
    |-> positive_input_o == config_word_o[9:7] && negative_input_o == (config_word_o[9:7] ^ 3'h1))
    else $error("idle pair inputs wrong");
  AST_SEQ_PAIR: assert property (s_sel ##0 (seq_active_o && negative_select_o == `NEG_PAIR)
    |-> !positive_input_o[0] && negative_input_o == positive_input_o + 1'b1)
    else $error("sequenced pair not even over odd");
  AST_TEMP_BIN: assert property (conv_select_o && temp_select_o
    |-> !twos_complement_o && seq_active_o) else $error("sensor conversion wrong");
  AST_WORD: assert property (!$stable(config_word_o) |-> config_word_o[`CFG_UPDATE_BIT])
    else $error("word changed without update bit");
endmodule // adc_seq_chk

bind adc_input_config_sequencer adc_seq_chk #(.CH_BITS(CH_BITS)) i_chk (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .config_word_o(config_word_o),
  .conv_select_o(conv_select_o), .positive_input_o(positive_input_o),
  .negative_input_o(negative_input_o), .negative_select_o(negative_select_o),
  .negative_half_ref_o(negative_half_ref_o), .temp_select_o(temp_select_o),
  .twos_complement_o(twos_complement_o), .bw_quarter_o(bw_quarter_o),
  .seq_active_o(seq_active_o));

// ---- tb/host_model.sv ----
// Host side of the serial port: shifts words and starts conversions
`timescale 1ns/1ns
module host_model
(
  input  wire clk_i,
  output reg  convert_start_pin_o,
  output reg  sck_o,
  output reg  din_o
);
  initial
  begin
    convert_start_pin_o = 1'b0;
    sck_o = 1'b0;
    din_o = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // One frame of nb bits MSB first; serial clock stands low outside it
  task automatic xfer(input logic [13:0] w, input integer nb, input integer gap);
    integer k;
    begin
      @(negedge clk_i);
      convert_start_pin_o = 1'b0;
      repeat (4) @(negedge clk_i);
      for (k = 0; k < nb; k = k + 1)
      begin
        din_o = (k < 14) ? w[13 - k] : 1'b0;
        repeat (4) @(negedge clk_i);
        sck_o = 1'b1;
        repeat (4) @(negedge clk_i);
        sck_o = 1'b0;
      end
      din_o = 1'b0;
      repeat (8) @(negedge clk_i);
      convert_start_pin_o = 1'b1;
      repeat (gap) @(negedge clk_i);
    end
  endtask
endmodule // host_model

// ---- tb/tb.sv ----
// Self-checking bench for the input decoder and channel sequencer
`timescale 1ns/1ns
module tb;
  reg         clk_i;
  reg         sys_rst_i;
  wire        pin;
  wire        sck;
  wire        din;
  wire [13:0] word_o;
  wire        conv_sel;
  wire [2:0]  pos;
  wire [2:0]  neg;
  wire [1:0]  nsel;
  wire        half;
  wire        temp;
  wire        twos;
  wire        quarter;
  wire [2:0]  refs;
  wire        readback;
  wire        act;
  reg  [2:0]  c_pos;
  reg  [2:0]  c_neg;
  reg  [1:0]  c_nsel;
  reg         c_half;
  reg         c_temp;
  reg         c_twos;
  reg         c_act;
  integer     n_conv = 0;
  integer     err_count;
  integer     n_compared;
  reg  [13:0] m_word;
  integer     m_idx;
  integer     m_act;
  integer     m_tmode;
  reg  [31:0] rs;
  reg  [13:0] w;
  reg  [4:0]  i;

  always #4 clk_i = ~clk_i;

  adc_input_config_sequencer #(.CH_BITS(3)) i_dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .convert_start_pin_i(pin), .sck_i(sck),
    .din_i(din), .config_word_o(word_o), .conv_select_o(conv_sel), .positive_input_o(pos),
    .negative_input_o(neg), .negative_select_o(nsel), .negative_half_ref_o(half),
    .temp_select_o(temp), .twos_complement_o(twos), .bw_quarter_o(quarter),
    .ref_select_o(refs), .config_readback_o(readback), .seq_active_o(act));

  host_model i_host (.clk_i(clk_i), .convert_start_pin_o(pin), .sck_o(sck), .din_o(din));

  //////////////////////////////////////////////////////////////////////////////
  // Catch the selection of each conversion in the cycle of its pulse
  always @(posedge clk_i)
  begin
    if (conv_sel === 1'b1)
    begin
      c_pos <= pos;
      c_neg <= neg;
      c_nsel <= nsel;
      c_half <= half;
      c_temp <= temp;
      c_twos <= twos;
      c_act <= act;
      n_conv <= n_conv + 1;
    end
  end

  function automatic [31:0] xs(input [31:0] x);
    begin
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
    end
  endfunction

  task chk(input logic [13:0] got, input logic [13:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp)
      begin
        err_count = err_count + 1;
        $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask

  task print_verdict;
    begin
      $display("compared %0d mismatched %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Reference model: an update write keeps the scan unless its shape changes
  task model_word(input logic [13:0] v);
    begin
      if (v[2:1] == 2'h1)
      begin
        if (m_act && (v[11] != m_word[11] || v[9:7] != m_word[9:7]))
          m_idx = 0;
      end
      else
      begin
        m_act = (v[2:1] != 2'h0);
        m_tmode = (v[2:1] == 2'h2);
        m_idx = 0;
      end
      m_word = v;
    end
  endtask

  // One frame plus conversion, then its results against the model; input selection is skipped for the sensor, the negative input for singles
  task do_xfer(input logic [13:0] v, input integer nb);
    integer n0;
    integer n;
    integer e_pos;
    integer e_temp;
    begin
      n0 = n_conv;
      if (nb >= 14 && v[13])
        model_word(v);
      i_host.xfer(v, nb, m_word[6] ? 16 : 64);
      n = m_word[11] ? m_word[9:7] + 1 : m_word[9:8] + 1;
      e_temp = 0;
      e_pos = m_word[9:7];
      if (m_act)
      begin
        if (m_idx < n)
          e_pos = m_word[11] ? m_idx : 2 * m_idx;
        else
          e_temp = 1;
        m_idx = (m_idx + 1) % (n + m_tmode);
      end
      chk(n_conv - n0, 14'h0001);
      chk(word_o, m_word);
      chk(quarter, !m_word[6]);
      chk(refs, m_word[5:3]);
      chk(readback, m_word[0]);
      chk(c_act, m_act);
      chk(c_temp, e_temp);
      chk(c_twos, !e_temp && !m_word[12]);
      if (!e_temp)
      begin
        chk(c_pos, e_pos);
        chk(c_nsel, m_word[11] ? (m_word[12:10] == 3'h7 ? 0 : 1) : 2);
        chk(c_half, !m_word[12]);
        if (!m_word[11])
          chk(c_neg, m_act ? e_pos + 1 : e_pos ^ 1);
      end
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence: codes, two scans, updates, refused words, random traffic
  initial
  begin
    clk_i = 1'b0;
    sys_rst_i = 1'b1;
    err_count = 0;
    n_compared = 0;
    m_word = 14'h0000;
    m_idx = 0;
    m_act = 0;
    m_tmode = 0;
    rs = 32'h384E;
    repeat (10) @(negedge clk_i);
    sys_rst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    chk(word_o, 14'h0000);
    chk(act, 14'h0000);
    for (i = 0; i < 16; i = i + 1)
      do_xfer({1'b1, i[2:0], 2'h0, i[3], 1'b1, i[2:0], 2'h0, i[3]}, 14);
    do_xfer(14'h3BC4, 14);
    repeat (11) do_xfer(14'h0000, 14);
    do_xfer(14'h2686, 14);
    repeat (2) do_xfer(14'h0000, 14);
    do_xfer(14'h2682, 14);
    do_xfer(14'h0000, 14);
    do_xfer(14'h2582, 14);
    repeat (2) do_xfer(14'h0000, 14);
    do_xfer(14'h3FFF, 7);
    do_xfer(14'h1FFF, 14);
    do_xfer(14'h3BC4, 16);
    repeat (40)
    begin
      rs = xs(rs);
      w = rs[20] ? {1'b1, rs[12:0]} : 14'h0000;
      if (w[2:1] == 2'h1)
        w[2] = 1'b1;
      do_xfer(w, 14);
    end
    print_verdict;
  end

  // Cut a hang short well past the expected run length
  initial
  begin
    #400000;
    err_count = err_count + 1;
    print_verdict;
  end
endmodule // tb
